//--- src/eic_pkg.sv
// Purpose: constants and carrier types of the encoder input/clock config bank
// Assumes: byte-wide registers reached by the serial port register interface
// Notes: register offsets are the byte addresses of the serial port map
//
// What this block does
// RULE1: definition select bit 0: 0 SD modes, 1 HD modes from mode 48.
// RULE2: reference boost bit 7 raises the DAC bandgap reference about 6%.
// RULE3: clock rate bit 0: 0 pixel rate, both edges; 1 double rate, one edge.
// RULE4: output clock rate bit 1: 0 pixel frequency, 1 twice pixel frequency.
// RULE5: input clock invert bit 2 flips the edge used to latch input data.
// RULE6: bit 3: 1 crystal with M and N, 0 input clock with dividers at one.
// RULE7: delay bits 3-0: bit 3 puts clock behind data, bits 2-0 count steps.
// RULE8: black level updates in vertical blanking only while bit 6 is set.
// RULE9: pixel clock pin driven only when bit 1 set; bit 0 inverts it.
// RULE10: output pins drive their data bit; input pins read the sampled level.
// RULE11: direction bits 7-6: 1 input, 0 plain output; both default to input.
// RULE12: input format field bits 2-0 selects how the 12-bit port is read.
// RULE13: sync polarity bits 3 and 4: 0 active low, 1 active high.
// RULE14: sync direction bit 5: 0 sync pins are inputs, 1 device drives them.
// RULE15: embedded sync bit 6 with format 4 takes sync from data codes.
// RULE16: sense 1 holds DACs steady; its fall zeroes unconnected detect bits.
// RULE17: software powers DACs, sets sense, clears it, then reads detect bits.
// RULE18: detect bits 4-1 undefined before a pass; then 1 connected, 0 not.
// RULE19: 3-bit oscillator gain: top in detect bit 6, low two in DAC control.
// RULE20: converter bypass bit 0 sends pixel data straight to the four DACs.
// RULE21: software sets gain bits 2-1 per standard; 01 for HD component.
// RULE22: sync output select bits 4-3 choose the sync on the shared pin.
// RULE23: written fields read back; reserved bits are stored with no effect.
package eic_pkg;
   localparam logic [7:0] ADDR_DEF_MODE = 8'h14;
   localparam logic [7:0] ADDR_CLK_MODE = 8'h1C;
   localparam logic [7:0] ADDR_CLK_DELAY = 8'h1D;
   localparam logic [7:0] ADDR_PIN_CTRL = 8'h1E;
   localparam logic [7:0] ADDR_FMT_CTRL = 8'h1F;
   localparam logic [7:0] ADDR_DETECT = 8'h20;
   localparam logic [7:0] ADDR_DAC_CTRL = 8'h21;

   localparam logic [7:0] RST_DEF_MODE = 8'h02;
   localparam logic [7:0] RST_CLK_MODE = 8'h00;
   localparam logic [7:0] RST_CLK_DELAY = 8'h48;
   localparam logic [7:0] RST_PIN_CTRL = 8'hF0;
   localparam logic [7:0] RST_FMT_CTRL = 8'h80;
   // detect status has no defined value; the stored bits reset like this
   localparam logic [7:0] RST_DETECT = 8'h40;
   localparam logic [7:0] RST_DAC_CTRL = 8'h00;

   localparam int BIT_DEF_SEL = 0;
   localparam int BIT_REF_BOOST = 7;
   localparam int BIT_IN_RATE = 0;
   localparam int BIT_OUT_RATE = 1;
   localparam int BIT_IN_INV = 2;
   localparam int BIT_MASTER = 3;
   localparam int BIT_DLY_BEHIND = 3;
   localparam int BIT_BLACK_EN = 6;
   localparam int BIT_POUT_POL = 0;
   localparam int BIT_POUT_EN = 1;
   localparam int BIT_PIN_DATA = 4;
   localparam int BIT_PIN_DIR = 6;
   localparam int BIT_HS_POL = 3;
   localparam int BIT_VS_POL = 4;
   localparam int BIT_SYNC_DIR = 5;
   localparam int BIT_EMB_SYNC = 6;
   localparam int BIT_IN_BUF = 7;
   localparam int BIT_SENSE = 0;
   localparam int BIT_DETECT_LO = 1;
   localparam int BIT_OSC_HI = 6;
   localparam int BIT_BYPASS = 0;
   localparam int BIT_GAIN_LO = 1;
   localparam int BIT_SYNC_SEL_LO = 3;
   localparam int BIT_OSC_LO = 6;

   localparam logic [2:0] FMT_EMBEDDED = 3'h4;
   localparam logic [3:0] DETECT_MASK = 4'hF;

   typedef enum logic [1:0] {
      EIC_SYNC_NONE = 2'h0,
      EIC_SYNC_VGA_H = 2'h1,
      EIC_SYNC_TV_C = 2'h2,
      EIC_SYNC_TV_H = 2'h3
   } eic_sync_sel_t;

   typedef enum logic [1:0] {
      EIC_SNS_IDLE = 2'h0,
      EIC_SNS_HOLD = 2'h1,
      EIC_SNS_DONE = 2'h3
   } eic_sense_t;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } eic_req_t;

   // decoded configuration handed to the datapath
   typedef struct packed {
      logic hd_mode;
      logic ref_boost;
      logic in_double_rate;
      logic out_double_rate;
      logic in_clk_invert;
      logic clk_master;
      logic dly_behind;
      logic [2:0] dly_steps;
      logic black_update_en;
      logic [2:0] in_format;
      logic hs_active_high;
      logic vs_active_high;
      logic sync_drive;
      logic use_embedded_sync;
      logic input_buffer_sel;
      logic converter_bypass;
      logic [1:0] converter_gain;
      logic [2:0] oscillator_gain;
      eic_sync_sel_t sync_out_select;
   } eic_cfg_t;
endpackage

//--- src/eic_pin_sync.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: pins are asynchronous to mclk
// Notes: a change counts once stages two and three agree
`timescale 1ns/10ps
module eic_pin_sync
#(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] INIT = '1
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // pins and filtered levels
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } eic_sync_st_t;

   eic_sync_st_t st;
   eic_sync_st_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (st.s2[i] == st.s3[i])
         begin
            next_st.lvl[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st <= {INIT, INIT, INIT, INIT};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign level = st.lvl;
endmodule

//--- src/eic_sense_ctrl.sv
// Purpose: DAC load-detect sequencing
// Assumes: comparator results are synchronised levels, 1 = load present
// Notes: detect bits change only on the falling edge of the sense bit
`timescale 1ns/10ps
module eic_sense_ctrl
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // control from the register bank
   input wire logic sense,
   input wire logic [3:0] load_present,
   // status and analog control
   output logic [3:0] load_detect_status,
   output logic dac_hold,
   output logic sense_done
);
   typedef struct packed {
      eic_pkg::eic_sense_t state;
      logic [3:0] status;
   } eic_sense_st_t;

   eic_sense_st_t st;
   eic_sense_st_t next_st;

   always_comb
   begin
      next_st = st;
      unique case (st.state)
         eic_pkg::EIC_SNS_IDLE,
         eic_pkg::EIC_SNS_DONE:
         begin
            if (sense)
            begin
               next_st.state = eic_pkg::EIC_SNS_HOLD;
            end
         end
         eic_pkg::EIC_SNS_HOLD:
         begin
            if (!sense)
            begin
               // unconnected outputs drop to 0; connected ones read 1
               next_st.status = load_present; // RULE16
               next_st.state = eic_pkg::EIC_SNS_DONE; // RULE18
            end
         end
         default:
         begin
            next_st.state = eic_pkg::EIC_SNS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         // status is meaningless before a pass; zero keeps simulation clean
         st <= '{state: eic_pkg::EIC_SNS_IDLE, status: 4'h0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign load_detect_status = st.status;
   assign dac_hold = (st.state == eic_pkg::EIC_SNS_HOLD); // RULE16
   assign sense_done = (st.state == eic_pkg::EIC_SNS_DONE);
endmodule

//--- src/eic_regs.sv
// Purpose: input, clock and converter configuration register bank
// Assumes: serial port decoder presents single-cycle read/write strobes
// Notes: read data is registered, valid one cycle after the read strobe
`timescale 1ns/10ps
module eic_regs
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // serial port register access
   input eic_pkg::eic_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   // general purpose pins, oe low while driving
   input wire logic [1:0] gp_pin_in,
   output logic [1:0] gp_pin_out,
   output logic [1:0] gp_pin_oe_n,
   // pixel clock output pin
   input wire logic pixel_clk_src,
   output logic pixel_clk_out,
   output logic pixel_clk_oe_n,
   // sync pins, oe low while driving
   input wire logic hsync_int,
   input wire logic vsync_int,
   output logic hsync_out,
   output logic vsync_out,
   output logic sync_oe_n,
   // sync sources for the shared pin
   input wire logic vga_hsync,
   input wire logic tv_csync,
   input wire logic tv_hsync,
   // black level update request from the timing generator
   input wire logic black_update_req,
   output logic black_update_go,
   // load detect comparators and converter control
   input wire logic [3:0] load_present,
   output logic dac_hold,
   // decoded configuration
   output eic_pkg::eic_cfg_t cfg
);
   typedef struct packed {
      logic [7:0] def_mode;
      logic [7:0] clk_mode;
      logic [7:0] clk_delay;
      logic [7:0] pin_ctrl;
      logic [7:0] fmt_ctrl;
      logic [7:0] detect;
      logic [7:0] dac_ctrl;
      logic [7:0] rdata;
      logic rvalid;
      logic black_go;
      logic [1:0] gp_out;
      logic [1:0] gp_oe_n;
   } eic_reg_st_t;

   eic_reg_st_t st;
   eic_reg_st_t next_st;
   logic [1:0] gp_level;
   logic [3:0] det_status;
   logic [7:0] detect_view;
   logic [7:0] pin_view;
   logic shared_sync;
   logic shared_sync_on;

   eic_pin_sync #(
      .WIDTH(2),
      .INIT(2'h3)
   ) u_gp_sync (
      .mclk(mclk),
      .rst(rst),
      .pin(gp_pin_in),
      .level(gp_level)
   );

   eic_sense_ctrl u_sense (
      .mclk(mclk),
      .rst(rst),
      .sense(st.detect[eic_pkg::BIT_SENSE]),
      .load_present(load_present),
      .load_detect_status(det_status),
      .dac_hold(dac_hold),
      .sense_done()
   );

   // read views: detect bits come from the sensing pass, input pins from the pads
   always_comb
   begin
      detect_view = st.detect;
      detect_view[eic_pkg::BIT_DETECT_LO +: 4] = det_status; // RULE18
      pin_view = st.pin_ctrl;
      for (int i = 0; i < 2; i++)
      begin
         if (st.pin_ctrl[eic_pkg::BIT_PIN_DIR + i])
         begin
            pin_view[eic_pkg::BIT_PIN_DATA + i] = gp_level[i]; // RULE10
         end
      end
   end

   // shared pin carries sync whenever a source is selected, whatever its direction bit
   always_comb
   begin
      shared_sync_on = 1'b1;
      unique case (cfg.sync_out_select) // RULE22
         eic_pkg::EIC_SYNC_NONE:
         begin
            shared_sync = 1'b0;
            shared_sync_on = 1'b0;
         end
         eic_pkg::EIC_SYNC_VGA_H:
         begin
            shared_sync = vga_hsync;
         end
         eic_pkg::EIC_SYNC_TV_C:
         begin
            shared_sync = tv_csync;
         end
         eic_pkg::EIC_SYNC_TV_H:
         begin
            shared_sync = tv_hsync;
         end
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_st.rvalid = req.rd;
      if (req.wr)
      begin
         // all fields hold written value; reserved bits are plain storage
         unique case (req.addr) // RULE23
            eic_pkg::ADDR_DEF_MODE: next_st.def_mode = req.wdata;
            eic_pkg::ADDR_CLK_MODE: next_st.clk_mode = req.wdata;
            eic_pkg::ADDR_CLK_DELAY: next_st.clk_delay = req.wdata;
            eic_pkg::ADDR_PIN_CTRL: next_st.pin_ctrl = req.wdata;
            eic_pkg::ADDR_FMT_CTRL: next_st.fmt_ctrl = req.wdata;
            eic_pkg::ADDR_DETECT: next_st.detect = req.wdata;
            eic_pkg::ADDR_DAC_CTRL: next_st.dac_ctrl = req.wdata;
            default: next_st.def_mode = st.def_mode;
         endcase
      end
      if (req.rd)
      begin
         unique case (req.addr)
            eic_pkg::ADDR_DEF_MODE: next_st.rdata = st.def_mode;
            eic_pkg::ADDR_CLK_MODE: next_st.rdata = st.clk_mode;
            eic_pkg::ADDR_CLK_DELAY: next_st.rdata = st.clk_delay;
            eic_pkg::ADDR_PIN_CTRL: next_st.rdata = pin_view;
            eic_pkg::ADDR_FMT_CTRL: next_st.rdata = st.fmt_ctrl;
            eic_pkg::ADDR_DETECT: next_st.rdata = detect_view;
            eic_pkg::ADDR_DAC_CTRL: next_st.rdata = st.dac_ctrl;
            default: next_st.rdata = 8'h00;
         endcase
      end
      // updates only pass while enabled; otherwise the request is dropped
      next_st.black_go = black_update_req &&
         st.clk_delay[eic_pkg::BIT_BLACK_EN]; // RULE8
      for (int i = 0; i < 2; i++)
      begin
         next_st.gp_oe_n[i] = st.pin_ctrl[eic_pkg::BIT_PIN_DIR + i]; // RULE11
         next_st.gp_out[i] = st.pin_ctrl[eic_pkg::BIT_PIN_DATA + i]; // RULE10
      end
      // pin 1 doubles as the sync output when a source is selected
      if (shared_sync_on)
      begin
         next_st.gp_oe_n[1] = 1'b0; // RULE22
         next_st.gp_out[1] = shared_sync;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st <= '{def_mode: eic_pkg::RST_DEF_MODE,
                 clk_mode: eic_pkg::RST_CLK_MODE,
                 clk_delay: eic_pkg::RST_CLK_DELAY,
                 pin_ctrl: eic_pkg::RST_PIN_CTRL,
                 fmt_ctrl: eic_pkg::RST_FMT_CTRL,
                 detect: eic_pkg::RST_DETECT,
                 dac_ctrl: eic_pkg::RST_DAC_CTRL,
                 rdata: 8'h00,
                 rvalid: 1'b0,
                 black_go: 1'b0,
                 gp_out: 2'h0,
                 gp_oe_n: 2'h3};
      end
      else
      begin
         st <= next_st;
      end
   end

   // decoded configuration
   always_comb
   begin
      cfg.hd_mode = st.def_mode[eic_pkg::BIT_DEF_SEL]; // RULE1
      cfg.ref_boost = st.def_mode[eic_pkg::BIT_REF_BOOST]; // RULE2
      cfg.in_double_rate = st.clk_mode[eic_pkg::BIT_IN_RATE]; // RULE3
      cfg.out_double_rate = st.clk_mode[eic_pkg::BIT_OUT_RATE]; // RULE4
      cfg.in_clk_invert = st.clk_mode[eic_pkg::BIT_IN_INV]; // RULE5
      cfg.clk_master = st.clk_mode[eic_pkg::BIT_MASTER]; // RULE6
      cfg.dly_behind = st.clk_delay[eic_pkg::BIT_DLY_BEHIND]; // RULE7
      cfg.dly_steps = st.clk_delay[2:0]; // RULE7
      cfg.black_update_en = st.clk_delay[eic_pkg::BIT_BLACK_EN];
      cfg.in_format = st.fmt_ctrl[2:0]; // RULE12
      cfg.hs_active_high = st.fmt_ctrl[eic_pkg::BIT_HS_POL]; // RULE13
      cfg.vs_active_high = st.fmt_ctrl[eic_pkg::BIT_VS_POL]; // RULE13
      cfg.sync_drive = st.fmt_ctrl[eic_pkg::BIT_SYNC_DIR]; // RULE14
      // embedded sync is only honoured for the embedded-code format
      cfg.use_embedded_sync = st.fmt_ctrl[eic_pkg::BIT_EMB_SYNC] &&
         (st.fmt_ctrl[2:0] == eic_pkg::FMT_EMBEDDED); // RULE15
      cfg.input_buffer_sel = st.fmt_ctrl[eic_pkg::BIT_IN_BUF];
      cfg.converter_bypass = st.dac_ctrl[eic_pkg::BIT_BYPASS]; // RULE20
      cfg.converter_gain = st.dac_ctrl[eic_pkg::BIT_GAIN_LO +: 2];
      cfg.oscillator_gain = {st.detect[eic_pkg::BIT_OSC_HI],
         st.dac_ctrl[eic_pkg::BIT_OSC_LO +: 2]}; // RULE19
      cfg.sync_out_select = eic_pkg::eic_sync_sel_t'(
         st.dac_ctrl[eic_pkg::BIT_SYNC_SEL_LO +: 2]);
   end

   assign rdata = st.rdata;
   assign rvalid = st.rvalid;
   assign black_update_go = st.black_go;
   assign gp_pin_out = st.gp_out;
   assign gp_pin_oe_n = st.gp_oe_n;
   // clock path stays combinational so the pad sees no mclk sampling
   assign pixel_clk_out =
      pixel_clk_src ^ st.pin_ctrl[eic_pkg::BIT_POUT_POL]; // RULE9
   assign pixel_clk_oe_n = ~st.pin_ctrl[eic_pkg::BIT_POUT_EN]; // RULE9
   assign hsync_out = hsync_int;
   assign vsync_out = vsync_int;
   assign sync_oe_n = ~st.fmt_ctrl[eic_pkg::BIT_SYNC_DIR]; // RULE14
endmodule

//--- test/eic_pad_model.sv
// Purpose: board side of the two general pins
// Assumes: weak pull-up on each pin, optional external switch
// Notes: an undriven pin floats up, never keeps the last driven value
`timescale 1ns/10ps
module eic_pad_model
(
   // device side
   input wire logic [1:0] gp_pin_out,
   input wire logic [1:0] gp_pin_oe_n,
   // external switch
   input wire logic [1:0] ext_en,
   input wire logic [1:0] ext_val,
   // resolved level
   output logic [1:0] gp_pin_in
);
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (!gp_pin_oe_n[i])
            gp_pin_in[i] = gp_pin_out[i];
         else if (ext_en[i])
            gp_pin_in[i] = ext_val[i];
         else
            gp_pin_in[i] = 1'b1;
      end
   end
endmodule

//--- test/eic_regs_monitor.sv
// Purpose: port checker for the config register bank
// Assumes: one clock domain, synchronous reset
// Notes: pin checks wait two idle cycles to cover the output flop
`timescale 1ns/10ps
module eic_regs_monitor
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input eic_pkg::eic_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   // pins
   input wire logic [1:0] gp_pin_out,
   input wire logic [1:0] gp_pin_oe_n,
   input wire logic pixel_clk_src,
   input wire logic pixel_clk_out,
   input wire logic pixel_clk_oe_n,
   input wire logic hsync_int,
   input wire logic hsync_out,
   input wire logic sync_oe_n,
   // status and requests
   input wire logic black_update_req,
   input wire logic black_update_go,
   input wire logic dac_hold,
   input eic_pkg::eic_cfg_t cfg
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire w14 = req.wr && req.addr == 8'h14;
   wire w1e = req.wr && req.addr == 8'h1E;
   wire w1f = req.wr && req.addr == 8'h1F;
   wire w20 = req.wr && req.addr == 8'h20;
   wire mapped = req.addr inside {8'h14, [8'h1C:8'h21]};
   property p_rd; req.rd |=> rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_rv; rvalid |-> $past(req.rd); endproperty
   a_rv: assert property (p_rv) else $error("stray rvalid");
   property p_unm; req.rd && !mapped |=> rdata == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_hd;
      w14 |=> {cfg.ref_boost, cfg.hd_mode} ==
         $past({req.wdata[7], req.wdata[0]});
   endproperty
   a_hd: assert property (p_hd) else $error("mode bits wrong");
   property p_poe; w1e |=> pixel_clk_oe_n == !$past(req.wdata[1]); endproperty
   a_poe: assert property (p_poe) else $error("pclk enable");
   property p_pol;
      w1e |=> pixel_clk_out == (pixel_clk_src ^ $past(req.wdata[0]));
   endproperty
   a_pol: assert property (p_pol) else $error("pclk polarity");
   property p_gp;
      w1e && !req.wdata[6] ##1 !w1e [*2] |->
         !gp_pin_oe_n[0] && gp_pin_out[0] == $past(req.wdata[4], 2);
   endproperty
   a_gp: assert property (p_gp) else $error("pin0 output");
   property p_syo; w1f |=> sync_oe_n == !$past(req.wdata[5]); endproperty
   a_syo: assert property (p_syo) else $error("sync direction");
   property p_hs; !sync_oe_n |-> hsync_out == hsync_int; endproperty
   a_hs: assert property (p_hs) else $error("hsync output");
   property p_blk;
      black_update_go |-> $past(black_update_req && cfg.black_update_en);
   endproperty
   a_blk: assert property (p_blk) else $error("black update");
   property p_blk2;
      black_update_req && cfg.black_update_en |=> black_update_go;
   endproperty
   a_blk2: assert property (p_blk2) else $error("black lost");
   property p_hold; w20 ##1 !w20 |=> dac_hold == $past(req.wdata[0], 2);
   endproperty
   a_hold: assert property (p_hold) else $error("dac hold");
   c_sense: cover property ($fell(dac_hold));
   c_blk: cover property (black_update_go);
   c_unm: cover property (req.rd && !mapped);
endmodule
bind eic_regs eic_regs_monitor mon_u (.mclk, .rst, .req, .rdata, .rvalid,
   .gp_pin_out, .gp_pin_oe_n, .pixel_clk_src, .pixel_clk_out, .pixel_clk_oe_n,
   .hsync_int, .hsync_out, .sync_oe_n, .black_update_req, .black_update_go,
   .dac_hold, .cfg);

//--- test/eic_regs_tb.sv
// Purpose: self-checking bench of the config register bank
// Assumes: pads resolved by the pad model, pull-up when released
// Notes: expected values come from bench tables, literals and cfg_exp, never from the DUT
`timescale 1ns/10ps
module eic_regs_tb;
   logic mclk, rst, rvalid, pixel_clk_src, pixel_clk_out, pixel_clk_oe_n;
   logic hsync_int, vsync_int, hsync_out, vsync_out, sync_oe_n, dac_hold;
   logic vga_hsync, tv_csync, tv_hsync, black_update_req, black_update_go;
   logic [7:0] rdata, a, d, e;
   logic [1:0] gp_pin_in, gp_pin_out, gp_pin_oe_n, ext_en, ext_val;
   logic [3:0] load_present, lp;
   eic_pkg::eic_req_t req;
   eic_pkg::eic_cfg_t cfg;
   int fail_count, checked;
   logic [7:0] all_addr [7] =
      '{8'h14, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21};
   logic [7:0] rst_val [7] =
      '{8'h02, 8'h00, 8'h48, 8'hF0, 8'h80, 8'h40, 8'h00};
   logic [7:0] rw_addr [5] = '{8'h14, 8'h1C, 8'h1D, 8'h1F, 8'h21};

   eic_regs dut_u (.mclk, .rst, .req, .rdata, .rvalid, .gp_pin_in, .gp_pin_out,
      .gp_pin_oe_n, .pixel_clk_src, .pixel_clk_out, .pixel_clk_oe_n,
      .hsync_int, .vsync_int, .hsync_out, .vsync_out, .sync_oe_n, .vga_hsync,
      .tv_csync, .tv_hsync, .black_update_req, .black_update_go,
      .load_present, .dac_hold, .cfg);
   eic_pad_model pad_u (.gp_pin_out, .gp_pin_oe_n, .ext_en, .ext_val,
      .gp_pin_in);

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task chk(input string n, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // request released one cycle before the next one is raised
   task wr(input logic [7:0] ad, input logic [7:0] v);
      @(posedge mclk);
      #1 req = '{1'b1, 1'b0, ad, v};
      @(posedge mclk);
      #1 req.wr = 1'b0;
   endtask

   task rd(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge mclk);
      #1 req = '{1'b0, 1'b1, ad, 8'h00};
      @(posedge mclk);
      #1 req.rd = 1'b0;
      chk("rvalid", 8'h01, {7'h00, rvalid});
      chk("rdata", exp, rdata);
   endtask

   function automatic logic [7:0] cfg_exp(input logic [7:0] ad, v);
      case (ad)
         8'h14: return {6'h00, v[7], v[0]};
         8'h1C: return {4'h0, v[3:0]};
         8'h1D: return {3'h0, v[6], v[3:0]};
         8'h1F: return {v[7], v[6] && v[2:0] == 3'h4, v[5:0]};
         default: return {v[7:6], 1'b0, v[4:0]};
      endcase
   endfunction

   function automatic logic [7:0] cfg_view(input logic [7:0] ad);
      case (ad)
         8'h14: return {6'h00, cfg.ref_boost, cfg.hd_mode};
         8'h1C: return {4'h0, cfg.clk_master, cfg.in_clk_invert,
            cfg.out_double_rate, cfg.in_double_rate};
         8'h1D: return {3'h0, cfg.black_update_en, cfg.dly_behind,
            cfg.dly_steps};
         8'h1F: return {cfg.input_buffer_sel, cfg.use_embedded_sync,
            cfg.sync_drive, cfg.vs_active_high, cfg.hs_active_high,
            cfg.in_format};
         default: return {cfg.oscillator_gain[1:0], 1'b0,
            cfg.sync_out_select, cfg.converter_gain, cfg.converter_bypass};
      endcase
   endfunction

   task wrap_up;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      fail_count++;
      wrap_up();
   end

   initial
   begin
      fail_count = 0;
      checked = 0;
      rst = 1'b1;
      req = '0;
      {pixel_clk_src, hsync_int, vsync_int, black_update_req} = 4'h0;
      {vga_hsync, tv_csync, tv_hsync} = 3'h0;
      ext_en = 2'h0;
      ext_val = 2'h0;
      load_present = 4'h0;
      void'($urandom(32'hC9F3));
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      cyc(4);
      for (int i = 0; i < 7; i++)
         rd(all_addr[i], rst_val[i]);
      chk("pin_oe", 8'h03, {6'h00, gp_pin_oe_n});
      for (int i = 0; i < 40; i++)
      begin
         a = rw_addr[i % 5];
         d = (i < 5) ? 8'hFF : (i < 10) ? 8'h00 : 8'($urandom());
         wr(a, d);
         chk("cfg", cfg_exp(a, d), cfg_view(a));
         rd(a, d);
      end
      wr(8'h22, 8'hFF);
      rd(8'h22, 8'h00);
      rd(8'h13, 8'h00);
      wr(8'h1F, 8'h44);
      chk("emb", 8'h01, {7'h00, cfg.use_embedded_sync});
      wr(8'h21, 8'h02);
      chk("gain", 8'h01, {6'h00, cfg.converter_gain});
      wr(8'h21, 8'h00);
      wr(8'h1E, 8'hC0);
      ext_en = 2'h3;
      ext_val = 2'h1;
      cyc(6);
      rd(8'h1E, 8'hD0);
      ext_en = 2'h0;
      cyc(6);
      rd(8'h1E, 8'hF0);
      wr(8'h1E, 8'h20);
      cyc(2);
      chk("pins", 8'h02, {4'h0, gp_pin_oe_n, gp_pin_out});
      rd(8'h1E, 8'h20);
      for (int k = 1; k < 4; k++)
      begin
         {vga_hsync, tv_csync, tv_hsync} = 3'($urandom());
         wr(8'h21, 8'(k << 3));
         cyc(2);
         e = {7'h00, k == 1 ? vga_hsync : k == 2 ? tv_csync : tv_hsync};
         chk("pin1", e, {6'h00, gp_pin_oe_n[1], gp_pin_out[1]});
      end
      for (int k = 0; k < 8; k++)
      begin
         pixel_clk_src = k[2];
         wr(8'h1E, {6'h3C, k[1:0]});
         e = {6'h00, !k[1], k[0] ^ k[2]};
         chk("pclk", e, {6'h00, pixel_clk_oe_n, pixel_clk_out});
      end
      wr(8'h1F, 8'hA0);
      hsync_int = 1'($urandom());
      vsync_int = ~hsync_int;
      cyc(1);
      e = {5'h0, 1'b0, hsync_int, vsync_int};
      chk("sync", e, {5'h0, sync_oe_n, hsync_out, vsync_out});
      wr(8'h1F, 8'h80);
      chk("sync_oe", 8'h01, {7'h00, sync_oe_n});
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h1D, {1'b0, k[0], 6'h08});
         black_update_req = 1'b1;
         cyc(1);
         black_update_req = 1'b0;
         chk("black", {7'h00, k[0]}, {7'h00, black_update_go});
      end
      for (int k = 0; k < 3; k++)
      begin
         lp = (k == 0) ? 4'hA : (k == 1) ? 4'h0 : 4'($urandom());
         load_present = lp;
         wr(8'h49, 8'h00);
         wr(8'h20, 8'h41);
         cyc(1);
         chk("hold", 8'h01, {7'h00, dac_hold});
         wr(8'h20, 8'h40);
         cyc(2);
         load_present = ~lp;
         rd(8'h20, {3'b010, lp, 1'b0});
      end
      wr(8'h20, 8'hBE);
      chk("osc2", 8'h00, {7'h00, cfg.oscillator_gain[2]});
      rd(8'h20, {3'b101, lp, 1'b0});
      wrap_up();
   end
endmodule
